// File: core/ttc_unit.sv
// Three timer/counters behind an APB slave: two four-mode timers and a
// capture-mode third timer. Assumes pins are asynchronous to pclk.
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module ttc_unit (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // External pins
   input wire ttc_pkg::ttc_pins_s pins,
   // Overflow and event flags for the interrupt controller
   output logic overflow_flag_zero,
   output logic overflow_flag_one,
   output logic third_overflow_flag,
   output logic ext_event_flag
);

   // ****************************************
   // Registers
   // ****************************************
   logic [2:0] clock_speed_ctrl_r;
   logic [7:0] timer_mode_reg_r;
   logic run0_r, run1_r, run2_r;
   logic ovf0_r, ovf1_r, ovf2_r, exf_r;
   logic src2_r, cap_sel_r, ext_en_r, opt12_r;
   logic [7:0] tl0_r, th0_r, tl1_r, th1_r, tl2_r, th2_r;
   logic [7:0] cap_lo_r, cap_hi_r;
   logic [5:0] sync1_r, sync2_r, prev_r;

   // ****************************************
   // Pin synchronisers and fall detect
   // ****************************************
   logic [5:0] pin_vec;
   logic [5:0] fall;
   assign pin_vec = pins;

   // Idle-high reset level, so no false fall follows reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= 6'h3f;
         sync2_r <= 6'h3f;
         prev_r <= 6'h3f;
      end else begin
         sync1_r <= pin_vec;
         sync2_r <= sync1_r;
         prev_r <= sync2_r;
      end
   end
   assign fall = prev_r & ~sync2_r;

   // Bit order of the packed struct: msb first
   logic fall_cnt0, fall_cnt1, fall_cnt2, fall_cap, gate_pin0, gate_pin1;
   assign fall_cnt0 = fall[5];
   assign fall_cnt1 = fall[4];
   assign fall_cnt2 = fall[3];
   assign fall_cap = fall[2];
   assign gate_pin0 = sync2_r[1];
   assign gate_pin1 = sync2_r[0];

   // ****************************************
   // Prescalers, one per timer
   // ****************************************
   logic [2:0] tick;
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_pre
         logic [3:0] limit;
         logic [3:0] div_cnt_r;
         // Option bit forces slow rate regardless of turbo
         assign limit = (clock_speed_ctrl_r[gi] && !opt12_r) ?
                        ttc_pkg::DIV_TURBO : ttc_pkg::DIV_SLOW;
         // Free running: the first step after run lands within one period
         assign tick[gi] = (div_cnt_r >= limit - 4'h1);
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               div_cnt_r <= 4'h0;
            end else if (tick[gi]) begin
               div_cnt_r <= 4'h0;
            end else begin
               div_cnt_r <= div_cnt_r + 4'h1;
            end
         end
      end
   endgenerate

   // ****************************************
   // Timer 0 / 1 control decode
   // ****************************************
   ttc_pkg::ttc_mode_e mode0, mode1;
   assign mode0 = ttc_pkg::ttc_mode_e'(timer_mode_reg_r[ttc_pkg::TMR0_MODE_LO +: 2]);
   assign mode1 = ttc_pkg::ttc_mode_e'(timer_mode_reg_r[ttc_pkg::TMR1_MODE_LO +: 2]);

   // Timer zero in mode 3 lends its high byte to timer one's run and flag
   logic split;
   assign split = (mode0 == ttc_pkg::TTC_MODE_SPLIT);

   logic step0, step1, step_th0, step2;
   assign step0 = run0_r && (!timer_mode_reg_r[ttc_pkg::TMR0_GATE] || gate_pin0) &&
                  (timer_mode_reg_r[ttc_pkg::TMR0_SRC] ? fall_cnt0 : tick[0]);
   // In split mode timer one ignores its run bit
   assign step1 = (split || run1_r) &&
                  (!timer_mode_reg_r[ttc_pkg::TMR1_GATE] || gate_pin1) &&
                  (timer_mode_reg_r[ttc_pkg::TMR1_SRC] ? fall_cnt1 : tick[1]) &&
                  (mode1 != ttc_pkg::TTC_MODE_SPLIT);
   // High byte is clock-only and ignores the gate
   assign step_th0 = split && run1_r && tick[0];
   // Only capture mode is built: with the select clear the third timer holds
   assign step2 = run2_r && cap_sel_r && (src2_r ? fall_cnt2 : tick[2]);

   // Shared next-count logic for the two four-mode timers
   function automatic logic [16:0] next_count(input ttc_pkg::ttc_mode_e m,
                                              input logic [7:0] lo, input logic [7:0] hi);
      logic [12:0] c13;
      logic [15:0] c16;
      c13 = {hi, lo[4:0]};
      c16 = {hi, lo};
      next_count = {1'b0, hi, lo};
      unique case (m)
         ttc_pkg::TTC_MODE13: begin
            // Upper three low-byte bits left untouched
            c13 = c13 + 13'h1;
            next_count = {(c13 == 13'h0), c13[12:5], lo[7:5], c13[4:0]};
         end
         ttc_pkg::TTC_MODE16: begin
            c16 = c16 + 16'h1;
            next_count = {(c16 == 16'h0), c16};
         end
         ttc_pkg::TTC_MODE8_RELOAD: begin
            // Reload from the high byte, which stays as it is
            if (lo == ttc_pkg::BYTE_TOP) begin
               next_count = {1'b1, hi, hi};
            end else begin
               next_count = {1'b0, hi, lo + 8'h1};
            end
         end
         ttc_pkg::TTC_MODE_SPLIT: begin
            // Low byte only, as an 8-bit counter
            next_count = {(lo == ttc_pkg::BYTE_TOP), hi, lo + 8'h1};
         end
      endcase
   endfunction

   logic [16:0] nc0, nc1;
   assign nc0 = next_count(mode0, tl0_r, th0_r);
   assign nc1 = next_count(mode1, tl1_r, th1_r);

   // ****************************************
   // APB decode
   // ****************************************
   logic wr_en, rd_en;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   // Zero wait states: every register answers in its access cycle
   assign pready = 1'b1;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   logic mapped;
   assign mapped = hit(paddr, ttc_pkg::OFF_CLOCK_SPEED_CTRL) ||
                   hit(paddr, ttc_pkg::OFF_TIMER_MODE_REG) ||
                   hit(paddr, ttc_pkg::OFF_TIMER_CTRL_REG) ||
                   hit(paddr, ttc_pkg::OFF_COUNT0) || hit(paddr, ttc_pkg::OFF_COUNT1) ||
                   hit(paddr, ttc_pkg::OFF_COUNT2) ||
                   hit(paddr, ttc_pkg::OFF_THIRD_CTRL_REG) ||
                   hit(paddr, ttc_pkg::OFF_CAPTURE_REG) ||
                   hit(paddr, ttc_pkg::OFF_OPTION_REG);
   // Unmapped words answer with an error; writes there are dropped
   assign pslverr = psel && penable && !mapped;

   logic w_speed, w_mode, w_ctrl, w_c0, w_c1, w_c2, w_ctrl2, w_opt;
   assign w_speed = wr_en && hit(paddr, ttc_pkg::OFF_CLOCK_SPEED_CTRL);
   assign w_mode = wr_en && hit(paddr, ttc_pkg::OFF_TIMER_MODE_REG);
   assign w_ctrl = wr_en && hit(paddr, ttc_pkg::OFF_TIMER_CTRL_REG);
   assign w_c0 = wr_en && hit(paddr, ttc_pkg::OFF_COUNT0);
   assign w_c1 = wr_en && hit(paddr, ttc_pkg::OFF_COUNT1);
   assign w_c2 = wr_en && hit(paddr, ttc_pkg::OFF_COUNT2);
   assign w_ctrl2 = wr_en && hit(paddr, ttc_pkg::OFF_THIRD_CTRL_REG);
   assign w_opt = wr_en && hit(paddr, ttc_pkg::OFF_OPTION_REG);

   // ****************************************
   // Configuration registers
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_speed_ctrl_r <= 3'h0;
         timer_mode_reg_r <= ttc_pkg::RST_BYTE;
         opt12_r <= 1'b0;
      end else begin
         if (w_speed) begin
            clock_speed_ctrl_r <= pwdata[2:0];
         end
         if (w_mode) begin
            timer_mode_reg_r <= pwdata[7:0];
         end
         if (w_opt) begin
            opt12_r <= pwdata[ttc_pkg::FIXED_TWELVE_OPT];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run0_r <= 1'b0;
         run1_r <= 1'b0;
         run2_r <= 1'b0;
         src2_r <= 1'b0;
         cap_sel_r <= 1'b0;
         ext_en_r <= 1'b0;
      end else begin
         if (w_ctrl) begin
            run0_r <= pwdata[ttc_pkg::RUN_BIT_ZERO];
            run1_r <= pwdata[ttc_pkg::RUN_BIT_ONE];
         end
         if (w_ctrl2) begin
            run2_r <= pwdata[ttc_pkg::RUN_BIT_TWO];
            src2_r <= pwdata[ttc_pkg::THIRD_SRC_SEL];
            cap_sel_r <= pwdata[ttc_pkg::CAPTURE_RELOAD_SEL];
            ext_en_r <= pwdata[ttc_pkg::EXT_CAPTURE_ENABLE];
         end
      end
   end

   // ****************************************
   // Flags: hardware set wins over software write
   // ****************************************
   // One update for all four sticky flags: a set beats a clearing write
   function automatic logic sticky_upd(input logic hw_set, input logic sw_wr,
                                       input logic sw_val, input logic cur);
      sticky_upd = hw_set || (sw_wr ? sw_val : cur);
   endfunction

   logic set0, set1, set2, set_exf;
   assign set0 = step0 && nc0[16];
   // Split mode hands timer one's flag to the high byte
   assign set1 = split ? (step_th0 && th0_r == ttc_pkg::BYTE_TOP) : (step1 && nc1[16]);
   assign set2 = step2 && ({th2_r, tl2_r} == ttc_pkg::MODE1_TOP);
   assign set_exf = cap_sel_r && ext_en_r && fall_cap;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovf0_r <= 1'b0;
         ovf1_r <= 1'b0;
         ovf2_r <= 1'b0;
         exf_r <= 1'b0;
      end else begin
         ovf0_r <= sticky_upd(set0, w_ctrl, pwdata[ttc_pkg::OVF_FLAG_ZERO], ovf0_r);
         ovf1_r <= sticky_upd(set1, w_ctrl, pwdata[ttc_pkg::OVF_FLAG_ONE], ovf1_r);
         ovf2_r <= sticky_upd(set2, w_ctrl2, pwdata[ttc_pkg::THIRD_OVF_FLAG], ovf2_r);
         exf_r <= sticky_upd(set_exf, w_ctrl2, pwdata[ttc_pkg::EXT_EVENT_FLAG], exf_r);
      end
   end

   // ****************************************
   // Count registers
   // ****************************************
   // A count write beats a step in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tl0_r <= ttc_pkg::RST_BYTE;
         th0_r <= ttc_pkg::RST_BYTE;
      end else if (w_c0) begin
         tl0_r <= pwdata[7:0];
         th0_r <= pwdata[15:8];
      end else begin
         if (step0) begin
            tl0_r <= nc0[7:0];
            if (!split) begin
               th0_r <= nc0[15:8];
            end
         end
         if (step_th0) begin
            th0_r <= th0_r + 8'h1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tl1_r <= ttc_pkg::RST_BYTE;
         th1_r <= ttc_pkg::RST_BYTE;
      end else if (w_c1) begin
         tl1_r <= pwdata[7:0];
         th1_r <= pwdata[15:8];
      end else if (step1) begin
         tl1_r <= nc1[7:0];
         th1_r <= nc1[15:8];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {th2_r, tl2_r} <= ttc_pkg::RST_WORD;
      end else if (w_c2) begin
         {th2_r, tl2_r} <= pwdata[15:0];
      end else if (step2) begin
         {th2_r, tl2_r} <= {th2_r, tl2_r} + 16'h1;
      end
   end

   // Capture takes the pre-increment count of the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_lo_r <= ttc_pkg::RST_BYTE;
         cap_hi_r <= ttc_pkg::RST_BYTE;
      end else if (set_exf) begin
         cap_lo_r <= tl2_r;
         cap_hi_r <= th2_r;
      end
   end

   // ****************************************
   // Read mux
   // ****************************************
   // Loaded at read setup so the word stands through the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         prdata <= 32'h0;
         unique case (paddr)
            ttc_pkg::OFF_CLOCK_SPEED_CTRL: prdata[2:0] <= clock_speed_ctrl_r;
            ttc_pkg::OFF_TIMER_MODE_REG: prdata[7:0] <= timer_mode_reg_r;
            ttc_pkg::OFF_TIMER_CTRL_REG: prdata[3:0] <= {ovf1_r, run1_r, ovf0_r, run0_r};
            ttc_pkg::OFF_COUNT0: prdata[15:0] <= {th0_r, tl0_r};
            ttc_pkg::OFF_COUNT1: prdata[15:0] <= {th1_r, tl1_r};
            ttc_pkg::OFF_COUNT2: prdata[15:0] <= {th2_r, tl2_r};
            ttc_pkg::OFF_THIRD_CTRL_REG:
               prdata[5:0] <= {exf_r, ovf2_r, ext_en_r, cap_sel_r, src2_r, run2_r};
            ttc_pkg::OFF_CAPTURE_REG: prdata[15:0] <= {cap_hi_r, cap_lo_r};
            ttc_pkg::OFF_OPTION_REG: prdata[3] <= opt12_r;
            default: prdata <= 32'h0;
         endcase
      end
   end

   assign overflow_flag_zero = ovf0_r;
   assign overflow_flag_one = ovf1_r;
   assign third_overflow_flag = ovf2_r;
   assign ext_event_flag = exf_r;

endmodule

// File: shared/ttc_pkg.sv
// Package for the triple timer/counter unit: register offsets, fields, resets.
// Assumes an APB master with 32-bit data and one aligned word per register.
package ttc_pkg;

   // ****************************************
   // Register byte offsets
   // ****************************************
   localparam logic [7:0] OFF_CLOCK_SPEED_CTRL = 8'h00;
   localparam logic [7:0] OFF_TIMER_MODE_REG = 8'h04;
   localparam logic [7:0] OFF_TIMER_CTRL_REG = 8'h08;
   localparam logic [7:0] OFF_COUNT0 = 8'h0c;
   localparam logic [7:0] OFF_COUNT1 = 8'h10;
   localparam logic [7:0] OFF_COUNT2 = 8'h14;
   localparam logic [7:0] OFF_THIRD_CTRL_REG = 8'h18;
   localparam logic [7:0] OFF_CAPTURE_REG = 8'h1c;
   localparam logic [7:0] OFF_OPTION_REG = 8'h20;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int TURBO_SEL_ZERO = 0;
   localparam int TURBO_SEL_ONE = 1;
   localparam int TURBO_SEL_TWO = 2;
   localparam int TMR0_MODE_LO = 0;
   localparam int TMR0_SRC = 2;
   localparam int TMR0_GATE = 3;
   localparam int TMR1_MODE_LO = 4;
   localparam int TMR1_SRC = 6;
   localparam int TMR1_GATE = 7;
   localparam int RUN_BIT_ZERO = 0;
   localparam int OVF_FLAG_ZERO = 1;
   localparam int RUN_BIT_ONE = 2;
   localparam int OVF_FLAG_ONE = 3;
   localparam int RUN_BIT_TWO = 0;
   localparam int THIRD_SRC_SEL = 1;
   localparam int CAPTURE_RELOAD_SEL = 2;
   localparam int EXT_CAPTURE_ENABLE = 3;
   localparam int THIRD_OVF_FLAG = 4;
   localparam int EXT_EVENT_FLAG = 5;
   localparam int FIXED_TWELVE_OPT = 3;

   // ****************************************
   // Reset values and timing
   // ****************************************
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [3:0] DIV_SLOW = 4'hc;
   localparam logic [3:0] DIV_TURBO = 4'h6;
   localparam logic [12:0] MODE0_TOP = 13'h1fff;
   localparam logic [15:0] MODE1_TOP = 16'hffff;
   localparam logic [7:0] BYTE_TOP = 8'hff;

   typedef enum logic [1:0] {
      TTC_MODE13,
      TTC_MODE16,
      TTC_MODE8_RELOAD,
      TTC_MODE_SPLIT
   } ttc_mode_e;

   typedef struct packed {
      logic count_pin_zero;
      logic count_pin_one;
      logic count_pin_two;
      logic capture_pin;
      logic gating_pin_zero;
      logic gating_pin_one;
   } ttc_pins_s;

endpackage

// File: sim/ttc_pin_model.sv
// Model of the pins around the timer unit: count pulses, gates, capture.
// Assumes the bench holds its commands steady while a case runs.
`timescale 1ns/1ps
module ttc_pin_model (
   // Clock
   input wire logic clk,
   // Commands from the bench
   input wire logic [2:0] pulse_en,
   input wire logic cap_low,
   input wire logic [1:0] gate_lvl,
   // Pins
   output ttc_pkg::ttc_pins_s pins
);
   logic [3:0] phase_r = 4'h0;
   always_ff @(posedge clk) begin
      phase_r <= (phase_r == 4'h9) ? 4'h0 : phase_r + 4'h1;
   end
   // One fall every ten cycles, low for four so the synchroniser sees it
   always_comb begin
      pins.count_pin_zero = !(pulse_en[0] && phase_r < 4'h4);
      pins.count_pin_one = !(pulse_en[1] && phase_r < 4'h4);
      pins.count_pin_two = !(pulse_en[2] && phase_r < 4'h4);
      pins.capture_pin = !cap_low;
      pins.gating_pin_zero = gate_lvl[0];
      pins.gating_pin_one = gate_lvl[1];
   end
endmodule

// File: sim/ttc_unit_asserts.sv
// Checker for the timer unit: APB answers, sticky flags, capture cause.
// Assumes it is bound to ttc_unit and sees only that module's ports.
`timescale 1ns/1ps
module ttc_unit_asserts (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave side
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pins and flags
   input wire ttc_pkg::ttc_pins_s pins,
   input wire logic overflow_flag_zero,
   input wire logic overflow_flag_one,
   input wire logic third_overflow_flag,
   input wire logic ext_event_flag
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic wr_ctl;
   logic wr_third;
   assign wr_ctl = psel && penable && pwrite && paddr == ttc_pkg::OFF_TIMER_CTRL_REG;
   assign wr_third = psel && penable && pwrite && paddr == ttc_pkg::OFF_THIRD_CTRL_REG;
   // ****************************************
   // Sequences
   // ****************************************
   sequence apb_access;
      psel && penable;
   endsequence
   sequence bad_access;
      psel && penable && paddr > 8'h20;
   endsequence
   // ****************************************
   // Properties
   // ****************************************
   chk_ready_access: assert property (apb_access |-> pready)
      else $error("pready low in access phase");
   chk_err_unmapped: assert property (bad_access |-> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   chk_err_mapped: assert property (apb_access ##0 (paddr <= 8'h20 && paddr[1:0] == 2'b00)
      |-> !pslverr) else $error("mapped access refused");
   // Read data only moves after a read setup
   chk_prdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
      else $error("read data moved without a read");
   chk_ovf0_sticky: assert property (
      overflow_flag_zero && !wr_ctl |=> overflow_flag_zero) else $error("flag zero dropped");
   chk_ovf1_sticky: assert property (
      overflow_flag_one && !wr_ctl |=> overflow_flag_one) else $error("flag one dropped");
   chk_third_sticky: assert property (
      third_overflow_flag && !wr_third |=> third_overflow_flag) else $error("flag two dropped");
   chk_ext_sticky: assert property (
      ext_event_flag && !wr_third |=> ext_event_flag) else $error("event flag dropped");
   // First sync flop saw the pin low three edges before the flag shows
   chk_cap_cause: assert property (
      $rose(ext_event_flag) && !$past(wr_third) |-> !$past(pins.capture_pin, 3))
      else $error("event flag without capture pin low");
endmodule

bind ttc_unit ttc_unit_asserts i_ttc_unit_asserts (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
   .overflow_flag_zero(overflow_flag_zero), .overflow_flag_one(overflow_flag_one),
   .third_overflow_flag(third_overflow_flag), .ext_event_flag(ext_event_flag));

// File: sim/ttc_unit_test.sv
// Self-checking bench for the timer unit: table of timer cases, then hand tests.
// Assumes an APB slave that may stretch the access phase with pready.
`timescale 1ns/1ps
module ttc_unit_test;
   typedef struct {
      int tmr;
      logic [1:0] mode;
      logic src, gate, turbo, opt;
      logic [15:0] pre, mask, expv;
      int per;
   } ttc_row_s;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_flag, cap_low, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [2:0] flags, pulse_en;
   logic [1:0] gate_lvl;
   logic [3:0] evt;
   ttc_pkg::ttc_pins_s pins;
   int error_cnt = 0;
   int check_count = 0;
   int cyc = 0;
   int n;
   ttc_row_s rows [8] = '{
      '{0, 2'd0, 0, 0, 0, 0, 16'hfffd, 16'hff1f, 16'h0000, 12},
      '{0, 2'd1, 0, 1, 1, 0, 16'hfffd, 16'hffff, 16'h0000, 6},
      '{1, 2'd2, 0, 0, 0, 0, 16'h40fd, 16'hffff, 16'h4040, 12},
      '{1, 2'd1, 1, 0, 0, 0, 16'hfffd, 16'hffff, 16'h0000, 10},
      '{0, 2'd2, 0, 0, 1, 1, 16'h40fd, 16'hffff, 16'h4040, 12},
      '{0, 2'd1, 1, 0, 0, 0, 16'hfffd, 16'hffff, 16'h0000, 10},
      '{2, 2'd0, 0, 0, 1, 0, 16'hfffd, 16'hffff, 16'h0000, 6},
      '{2, 2'd0, 1, 0, 0, 0, 16'hfffd, 16'hffff, 16'h0000, 10}};
   assign evt = {ext_flag, flags};
   ttc_unit i_ttc_unit (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pins(pins), .overflow_flag_zero(flags[0]),
      .overflow_flag_one(flags[1]), .third_overflow_flag(flags[2]),
      .ext_event_flag(ext_flag));
   ttc_pin_model i_ttc_pin_model (.clk(pclk), .pulse_en(pulse_en), .cap_low(cap_low),
      .gate_lvl(gate_lvl), .pins(pins));
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // ****************************************
   // Tasks
   // ****************************************
   task automatic complete_run();
      $display("Checks %0d, errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt = error_cnt + 1;
         complete_run();
      end
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_rng(input int v, input int lo, input int hi);
      check_count++;
      if (v < lo || v > hi) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h to %h", $time, v, lo, hi);
      end
   endtask
   task automatic wait_hi(input int idx, input int lim);
      n = 0;
      while (evt[idx] !== 1'b1 && n < lim) begin
         @(posedge pclk);
         n++;
      end
   endtask
   task automatic run_row(input ttc_row_s r);
      logic [7:0] cnt_a;
      logic [31:0] run_d;
      cnt_a = ttc_pkg::OFF_COUNT0 + 8'(4 * r.tmr);
      run_d = (r.tmr == 2) ? {29'h0, 1'b1, r.src, 1'b1} : 32'(1) << (2 * r.tmr);
      wr(ttc_pkg::OFF_OPTION_REG, {28'h0, r.opt, 3'h0});
      wr(ttc_pkg::OFF_CLOCK_SPEED_CTRL, 32'(r.turbo) << r.tmr);
      wr(ttc_pkg::OFF_TIMER_MODE_REG,
         (r.tmr < 2) ? 32'({r.gate, r.src, r.mode}) << (4 * r.tmr) : 32'h0);
      wr(cnt_a, {16'h0, r.pre});
      pulse_en <= r.src ? 3'(1 << r.tmr) : 3'b000;
      wr((r.tmr == 2) ? ttc_pkg::OFF_THIRD_CTRL_REG : ttc_pkg::OFF_TIMER_CTRL_REG, run_d);
      wait_hi(r.tmr, 200);
      chk_rng(n, 2 * r.per, 3 * r.per + 6);
      rd(cnt_a);
      chk(rdat & {16'h0, r.mask}, {16'h0, r.expv});
      wr(ttc_pkg::OFF_TIMER_CTRL_REG, 32'h0);
      wr(ttc_pkg::OFF_THIRD_CTRL_REG, 32'h0);
      pulse_en <= 3'b000;
      @(posedge pclk);
      chk({29'h0, flags}, 32'h0);
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, cap_low} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pulse_en = 3'b000;
      gate_lvl = 2'b11;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i]) run_row(rows[i]);
      // Gate pin low holds the count
      gate_lvl <= 2'b10;
      wr(ttc_pkg::OFF_TIMER_MODE_REG, 32'h09);
      wr(ttc_pkg::OFF_COUNT0, 32'h0);
      wr(ttc_pkg::OFF_TIMER_CTRL_REG, 32'h1);
      repeat (40) @(posedge pclk);
      rd(ttc_pkg::OFF_COUNT0);
      chk(rdat, 32'h0);
      gate_lvl <= 2'b11;
      repeat (40) @(posedge pclk);
      rd(ttc_pkg::OFF_COUNT0);
      chk({31'h0, rdat != 32'h0}, 32'h1);
      // Split mode: high byte runs on the second run bit
      wr(ttc_pkg::OFF_TIMER_MODE_REG, 32'h13);
      wr(ttc_pkg::OFF_CLOCK_SPEED_CTRL, 32'h0);
      wr(ttc_pkg::OFF_TIMER_CTRL_REG, 32'h4);
      wr(ttc_pkg::OFF_COUNT1, 32'h0);
      wr(ttc_pkg::OFF_COUNT0, 32'hfdfd);
      wait_hi(1, 200);
      chk_rng(n, 24, 40);
      rd(ttc_pkg::OFF_COUNT0);
      chk(rdat, 32'h00fd);
      rd(ttc_pkg::OFF_COUNT1);
      chk({31'h0, rdat != 32'h0}, 32'h1);
      wr(ttc_pkg::OFF_TIMER_MODE_REG, 32'h31);
      wr(ttc_pkg::OFF_COUNT1, 32'h1234);
      repeat (40) @(posedge pclk);
      rd(ttc_pkg::OFF_COUNT1);
      chk(rdat, 32'h1234);
      // Capture of a stopped third timer
      wr(ttc_pkg::OFF_COUNT2, 32'habcd);
      wr(ttc_pkg::OFF_THIRD_CTRL_REG, 32'h0c);
      cap_low <= 1'b1;
      repeat (4) @(posedge pclk);
      cap_low <= 1'b0;
      wait_hi(3, 20);
      chk({31'h0, ext_flag}, 32'h1);
      rd(ttc_pkg::OFF_CAPTURE_REG);
      chk(rdat, 32'h0000abcd);
      // Capture pin ignored while its enable is clear
      wr(ttc_pkg::OFF_THIRD_CTRL_REG, 32'h04);
      cap_low <= 1'b1;
      repeat (4) @(posedge pclk);
      cap_low <= 1'b0;
      repeat (4) @(posedge pclk);
      chk({31'h0, ext_flag}, 32'h0);
      apb(1'b1, 8'h24, 32'hffffffff);
      chk({31'h0, err}, 32'h1);
      rd(8'h24);
      chk({31'h0, err}, 32'h1);
      chk(rdat, 32'h0);
      // Second reset in mid-run
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int a = 0; a <= 32; a += 4) begin
         rd(8'(a));
         chk(rdat, 32'h0);
      end
      complete_run();
   end
endmodule
